// ==== rtl/afe_cfg_pkg.sv ====
// Purpose: Shared constants for the video front-end configuration bank
// Assumes: Register index = printed offset, byte address = 4 * index
// Notes: Slot numbers count from the first register of the bank
package afe_cfg_pkg;

  localparam int NUM_REGS = 10;
  localparam int NUM_CH = 3;
  localparam int CLK_PERIOD_NS = 10;

  // Register indices; byte address on the bus is four times these
  localparam logic [5:0] IDX_RED_OFFSET = 6'h09;
  localparam logic [5:0] IDX_GREEN_OFFSET = 6'h0A;
  localparam logic [5:0] IDX_BLUE_OFFSET = 6'h0B;
  localparam logic [5:0] IDX_OFFSET_DAC_CONFIG = 6'h0C;
  localparam logic [5:0] IDX_FRONT_END_BANDWIDTH = 6'h0D;
  localparam logic [5:0] IDX_LINE_PIXEL_COUNT_HIGH = 6'h0E;
  localparam logic [5:0] IDX_LINE_PIXEL_COUNT_LOW = 6'h0F;
  localparam logic [5:0] IDX_SAMPLE_PHASE = 6'h10;
  localparam logic [5:0] IDX_COAST_BEFORE = 6'h11;
  localparam logic [5:0] IDX_COAST_AFTER = 6'h12;

  // Slots in the storage array
  localparam logic [3:0] SLOT_RED = 4'h0;
  localparam logic [3:0] SLOT_DAC_CFG = 4'h3;
  localparam logic [3:0] SLOT_BW = 4'h4;
  localparam logic [3:0] SLOT_COUNT_HI = 4'h5;
  localparam logic [3:0] SLOT_COUNT_LO = 4'h6;
  localparam logic [3:0] SLOT_PHASE = 4'h7;
  localparam logic [3:0] SLOT_COAST_BEFORE = 4'h8;
  localparam logic [3:0] SLOT_COAST_AFTER = 4'h9;

  // Values after reset, slot 9 first
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
    8'h04, 8'h04, 8'h00, 8'h20, 8'h03, 8'h2E, 8'h00, 8'h80, 8'h80, 8'h80
  };

  // Field positions
  localparam int DAC_RANGE_BIT = 0;
  localparam int DAC_LSB_BASE = 2;
  localparam int BW_LSB = 1;
  localparam int PEAK_LSB = 4;
  localparam int COUNT_HI_BITS = 6;
  localparam int PHASE_BITS = 6;

  localparam logic [3:0] PEAK_MAX_CODE = 4'h2;
  localparam logic [13:0] LINE_COUNT_MIN = 14'h0200;
  localparam logic [7:0] OFFSET_MID = 8'h80;
  localparam logic [9:0] DAC_CODE_RESET = 10'h200;
  localparam logic [13:0] LINE_COUNT_RESET = 14'h0320;
  // Phase step, thousandths of a degree
  localparam int PHASE_STEP_MDEG = 5625;

  typedef enum logic {APB_IDLE, APB_ANSWER} apb_state_t;

endpackage : afe_cfg_pkg

// ==== rtl/offset_path_if.sv ====
// Purpose: Carries offset settings to the DAC transfer logic and back
// Assumes: All signals on pclk
// Notes: Register side drives settings, path side drives codes
`timescale 1ns/1ps
interface offset_path_if;
  logic [2:0][7:0] offset;
  logic [2:0][1:0] dac_lsbs;
  logic auto_black_level_comp_en;
  logic clamp;
  logic ext_clamp;
  logic [2:0][9:0] dac_code;
  logic [2:0][7:0] digital_offset;

  modport regs (
    output offset, dac_lsbs, auto_black_level_comp_en, clamp, ext_clamp,
    input dac_code, digital_offset
  );
  modport path (
    input offset, dac_lsbs, auto_black_level_comp_en, clamp, ext_clamp,
    output dac_code, digital_offset
  );
endinterface : offset_path_if

// ==== rtl/offset_dac_xfer.sv ====
// Purpose: Forms per-channel DAC codes and digital offsets
// Assumes: Clamp input synchronous to pclk
// Notes: DAC codes move only on clamp events
`timescale 1ns/1ps
module offset_dac_xfer (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes state when low
  offset_path_if.path bus // Settings in, codes out
);
  import afe_cfg_pkg::*;

  logic clamp_d_r;
  wire logic clamp_lead = bus.clamp & ~clamp_d_r;
  // External clamp updates only on its leading edge
  wire logic xfer = bus.ext_clamp ? clamp_lead : bus.clamp;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_d_r <= 1'b0;
    end else if (clk_en) begin
      clamp_d_r <= bus.clamp;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [9:0] dac_r;
      logic [7:0] dig_r;
      // Eight offset bits above the two low DAC bits
      wire logic [9:0] dac_nxt = {bus.offset[ch], bus.dac_lsbs[ch]};
      // Two's complement view: 0x00 -> -128, 0x80 -> 0, 0xFF -> +127
      wire logic [7:0] dig_nxt = bus.auto_black_level_comp_en ? (bus.offset[ch] ^ OFFSET_MID)
                                             : 8'h00;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dac_r <= DAC_CODE_RESET;
          dig_r <= 8'h00;
        end else if (clk_en) begin
          if (xfer && !bus.auto_black_level_comp_en) begin
            dac_r <= dac_nxt;
          end
          dig_r <= dig_nxt;
        end
      end
      assign bus.dac_code[ch] = dac_r;
      assign bus.digital_offset[ch] = dig_r;
    end
  endgenerate

endmodule : offset_dac_xfer

// ==== rtl/video_afe_offset_pll_config_regs.sv ====
// Purpose: APB register bank for offset, bandwidth and PLL settings
// Assumes: APB4 master, all inputs synchronous to pclk
// Notes: Every access takes one wait state
//
// Overview of operation
// - AUTO_BLACK_LEVEL_COMP on: offset register is digital offset
// - AUTO_BLACK_LEVEL_COMP off: offset drives upper DAC bits
// - 0x00 min, 0x80 mid, 0xFF max
// - Range bit picks half or quarter span
// - DAC config holds two low bits per channel
// - Bandwidth bits 3:1 pick lowpass corner
// - Peaking codes 0,1,2; above two discouraged
// - Line count fourteen bits, high six, low eight
// - PLL count changes only on low write
// - Six-bit phase, 64 steps per pixel
// - Pre-coast lines before vertical sync
// - Post-coast lines after vertical sync
// - Registers load documented values at reset
// - DAC codes move at clamp pulse
`timescale 1ns/1ps
module video_afe_offset_pll_config_regs (
  input wire logic pclk, // Bus clock, 100 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  input wire logic auto_black_level_comp, // Black level loop on
  input wire logic clamp_pulse, // Clamp timing level
  input wire logic ext_clamp_sel, // Clamp comes from outside
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic [2:0][9:0] dac_code, // Offset DAC codes, red first
  output logic [2:0][7:0] digital_offset, // Signed digital offsets
  output logic dac_range_quarter, // DAC span quarter scale
  output logic [2:0] front_end_lowpass_corner, // Lowpass corner code
  output logic [3:0] peaking_code, // Peaking code
  output logic peaking_unsupported, // Peaking above two
  output logic [13:0] line_pixel_count, // Count to the PLL
  output logic line_count_too_small, // PLL count below minimum
  output logic [5:0] sample_phase_code, // Sampling phase step
  output logic [7:0] coast_before_lines, // Pre-coast lines
  output logic [7:0] coast_after_lines // Post-coast lines
);
  import afe_cfg_pkg::*;

  // Maps a byte address to a storage slot; bit 4 is the hit flag
  function automatic logic [4:0] slot_of(input logic [7:0] addr);
    logic [5:0] idx;
    logic [5:0] rel;
    idx = addr[7:2];
    rel = idx - IDX_RED_OFFSET;
    if (addr[1:0] == 2'b00 && idx >= IDX_RED_OFFSET &&
        idx <= IDX_COAST_AFTER) begin
      slot_of = {1'b1, rel[3:0]};
    end else begin
      slot_of = 5'h00;
    end
  endfunction : slot_of

  apb_state_t state_r;
  apb_state_t state_nxt;
  logic [7:0] regs_r [NUM_REGS];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [13:0] pll_count_r;
  logic range_r;
  logic [2:0] corner_r;
  logic [3:0] peak_r;
  logic peak_bad_r;
  logic count_small_r;
  logic [5:0] phase_r;
  logic [7:0] coast_before_r;
  logic [7:0] coast_after_r;

  // Bus decode
  wire logic access = psel & penable;
  wire logic [4:0] dec = slot_of(paddr);
  wire logic hit = dec[4];
  wire logic [3:0] slot = dec[3:0];
  // Write lands only at the completing edge, bad addresses are ignored
  wire logic done = access & pready_r;
  wire logic wr_fire = done & pwrite & hit & pstrb[0];
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic rd_hit_word = hit;
  wire logic [7:0] rd_byte = rd_hit_word ? regs_r[slot] : 8'h00;
  wire logic [31:0] rd_word = {24'h000000, rd_byte};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      APB_IDLE: begin
        if (access) begin
          state_nxt = APB_ANSWER;
        end
      end
      APB_ANSWER: begin
        if (done) begin
          state_nxt = APB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= APB_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Ready rises one cycle into the access phase and drops after it
  wire logic answer_start = (state_r == APB_IDLE) & access;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (clk_en) begin
      pready_r <= answer_start;
      if (answer_start) begin
        pslverr_r <= ~hit;
        prdata_r <= pwrite ? 32'h00000000 : rd_word;
      end else if (done) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // Storage: every byte keeps what software wrote, reserved bits too
  genvar s;
  generate
    for (s = 0; s < NUM_REGS; s++) begin : g_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_r[s] <= REG_RESET[s];
        end else if (clk_en && wr_fire && slot == 4'(s)) begin
          regs_r[s] <= wbyte;
        end
      end
    end
  endgenerate

  // The high byte sits in its slot until the low byte is written
  wire logic low_write = wr_fire & (slot == SLOT_COUNT_LO);
  wire logic [COUNT_HI_BITS-1:0] count_hi =
    regs_r[SLOT_COUNT_HI][COUNT_HI_BITS-1:0];
  wire logic [13:0] count_nxt = {count_hi, wbyte};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_count_r <= LINE_COUNT_RESET;
    end else if (clk_en && low_write) begin
      pll_count_r <= count_nxt;
    end
  end

  // Flag only: the PLL is not protected from a too small count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_small_r <= 1'b0;
    end else if (clk_en) begin
      count_small_r <= pll_count_r < LINE_COUNT_MIN;
    end
  end

  // Field extraction
  wire logic [7:0] dac_cfg = regs_r[SLOT_DAC_CFG];
  wire logic [7:0] bw_reg = regs_r[SLOT_BW];
  wire logic range_nxt = dac_cfg[DAC_RANGE_BIT];
  wire logic [2:0] corner_nxt = bw_reg[BW_LSB +: 3];
  wire logic [3:0] peak_nxt = bw_reg[PEAK_LSB +: 4];
  wire logic [5:0] phase_nxt = regs_r[SLOT_PHASE][PHASE_BITS-1:0];

  // Range: low = half scale, about one converter step per DAC step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_r <= 1'b0;
    end else if (clk_en) begin
      range_r <= range_nxt;
    end
  end

  // 000b is the slowest corner, 111b the fastest
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corner_r <= REG_RESET[SLOT_BW][BW_LSB +: 3];
    end else if (clk_en) begin
      corner_r <= corner_nxt;
    end
  end

  // Codes above two are passed through; software should avoid them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_r <= PEAK_MAX_CODE;
      peak_bad_r <= 1'b0;
    end else if (clk_en) begin
      peak_r <= peak_nxt;
      peak_bad_r <= peak_nxt > PEAK_MAX_CODE;
    end
  end

  // One step is a sixty-fourth of the pixel period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 6'h00;
    end else if (clk_en) begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coast_before_r <= REG_RESET[SLOT_COAST_BEFORE];
      coast_after_r <= REG_RESET[SLOT_COAST_AFTER];
    end else if (clk_en) begin
      coast_before_r <= regs_r[SLOT_COAST_BEFORE];
      coast_after_r <= regs_r[SLOT_COAST_AFTER];
    end
  end

  // Offset path
  offset_path_if opath ();

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_off
      assign opath.offset[c] = regs_r[4'(c) + SLOT_RED];
      assign opath.dac_lsbs[c] = dac_cfg[DAC_LSB_BASE + 2 * c +: 2];
    end
  endgenerate

  assign opath.auto_black_level_comp_en = auto_black_level_comp;
  assign opath.clamp = clamp_pulse;
  assign opath.ext_clamp = ext_clamp_sel;

  offset_dac_xfer u_xfer (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .bus(opath.path)
  );

  // Outputs, each straight from a flip-flop
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dac_code = opath.dac_code;
  assign digital_offset = opath.digital_offset;
  assign dac_range_quarter = range_r;
  assign front_end_lowpass_corner = corner_r;
  assign peaking_code = peak_r;
  assign peaking_unsupported = peak_bad_r;
  assign line_pixel_count = pll_count_r;
  assign line_count_too_small = count_small_r;
  assign sample_phase_code = phase_r;
  assign coast_before_lines = coast_before_r;
  assign coast_after_lines = coast_after_r;

endmodule : video_afe_offset_pll_config_regs

// ==== sim/afe_cfg_props.sv ====
// Purpose: Bus and field checks for the offset and PLL settings bank
// Assumes: One clock domain, bound to the bank top module
// Notes: Field outputs are judged two cycles after the completing edge
`timescale 1ns/1ps
module afe_cfg_props (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Run enable
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic auto_black_level_comp, // Black level loop on
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [2:0][9:0] dac_code, // Offset DAC codes
  input wire logic [2:0] front_end_lowpass_corner, // Corner code
  input wire logic [3:0] peaking_code, // Peaking code
  input wire logic [13:0] line_pixel_count // Count to the PLL
);
  logic wr_done;
  logic bad_addr;
  assign wr_done = psel && penable && pready && pwrite && pstrb[0];
  assign bad_addr = paddr < 8'h24 || paddr > 8'h48 || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  one_wait_a: assert property (
    psel && penable && !pready && clk_en |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  addr_error_a: assert property (
    psel && penable && pready |-> pslverr == bad_addr)
    else $error("error flag wrong");
  read_data_a: assert property (
    prdata != 32'h0 |-> pready && !pwrite && !pslverr &&
    prdata[31:8] == 24'h0)
    else $error("read data outside answer");
  corner_field_a: assert property (
    wr_done && paddr == 8'h34 |-> ##2
    {peaking_code, front_end_lowpass_corner} == $past(pwdata[7:1], 2))
    else $error("bandwidth fields wrong");
  count_hold_a: assert property (
    wr_done && paddr == 8'h38 |=> $stable(line_pixel_count)[*3])
    else $error("count moved on high write");
  count_load_a: assert property (
    wr_done && paddr == 8'h3C |-> ##2
    line_pixel_count[7:0] == $past(pwdata[7:0], 2))
    else $error("count low byte wrong");
  dac_hold_a: assert property (
    auto_black_level_comp |=> $stable(dac_code))
    else $error("dac code moved with loop on");
endmodule : afe_cfg_props

bind video_afe_offset_pll_config_regs afe_cfg_props u_props (.*);

// ==== sim/video_afe_offset_pll_config_regs_bench.sv ====
// Purpose: Self-checking bench for the offset and PLL settings bank
// Assumes: One wait state per access, fields settle within three cycles
// Notes: clk_en stays high; freezing is not exercised
`timescale 1ns/1ps
module video_afe_offset_pll_config_regs_bench;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, auto_black_level_comp = 0, clamp_pulse = 0;
  logic ext_clamp_sel = 0, pready, pslverr, dac_range_quarter;
  logic peaking_unsupported, line_count_too_small;
  logic [7:0] paddr = 0, coast_before_lines, coast_after_lines;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] pstrb = 0, peaking_code;
  logic [2:0][9:0] dac_code;
  logic [2:0][7:0] digital_offset;
  logic [2:0] front_end_lowpass_corner;
  logic [13:0] line_pixel_count;
  logic [5:0] sample_phase_code;
  int n_errors = 0, num_checks = 0;
  logic [7:0] rv [10] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h2E, 8'h03, 8'h20,
    8'h00, 8'h04, 8'h04};
  logic [31:0] q;
  logic e;
  video_afe_offset_pll_config_regs u_dut (.*);
  always #5 pclk = ~pclk;
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    for (int n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d}, 4'hF);
    chk("write error", 0, e);
    repeat (3) @(posedge pclk);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] ex);
    apb(0, a, 0, 4'h0);
    chk("read error", 0, e);
    chk("read data", {24'h0, ex}, q);
  endtask : rdc
  task automatic bad(input logic [7:0] a);
    apb(1, a, 32'hFF, 4'hF);
    chk("error write", 1, e);
    apb(0, a, 0, 4'h0);
    chk("error read", 1, e);
    chk("error data", 0, q);
  endtask : bad
  task automatic clamp;
    @(posedge pclk) clamp_pulse <= 1;
    @(posedge pclk) clamp_pulse <= 0;
    repeat (3) @(posedge pclk);
  endtask : clamp
  function automatic logic [7:0] pat(int i);
    return 8'hC3 ^ i[7:0];
  endfunction : pat
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 10; i++) rdc(8'h24 + 8'(4 * i), rv[i]);
    apb(1, 8'h44, 32'h77, 4'h0);
    rdc(8'h44, 8'h04);
    for (int i = 0; i < 10; i++) wr(8'h24 + 8'(4 * i), pat(i));
    for (int i = 0; i < 10; i++) rdc(8'h24 + 8'(4 * i), pat(i));
    chk("corner", pat(4) >> 1 & 8'h7, front_end_lowpass_corner);
    chk("peaking", pat(4) >> 4, peaking_code);
    chk("peak flag", 1, peaking_unsupported);
    chk("phase", pat(7) & 8'h3F, sample_phase_code);
    chk("pre coast", pat(8), coast_before_lines);
    chk("post coast", pat(9), coast_after_lines);
    chk("count", {pat(5) & 8'h3F, pat(6)}, line_pixel_count);
    wr(8'h38, 8'h3F);
    chk("count held", {pat(5) & 8'h3F, pat(6)}, line_pixel_count);
    wr(8'h3C, 8'h55);
    chk("count new", 14'h3F55, line_pixel_count);
    chk("small flag", 0, line_count_too_small);
    wr(8'h38, 8'h01);
    wr(8'h3C, 8'hFF);
    chk("small flag", 1, line_count_too_small);
    wr(8'h34, 8'h2E);
    chk("peak flag", 0, peaking_unsupported);
    bad(8'h4C);
    bad(8'h20);
    bad(8'h25);
    rdc(8'h24, pat(0));
    wr(8'h24, 8'h12);
    wr(8'h30, 8'h0D);
    wr(8'h2C, 8'h80);
    chk("dac before clamp", 10'h200, dac_code[0]);
    clamp();
    chk("dac red", 10'h04B, dac_code[0]);
    chk("range", 1, dac_range_quarter);
    chk("no digital", 0, digital_offset[0]);
    auto_black_level_comp <= 1;
    wr(8'h28, 8'h00);
    clamp();
    chk("dac held", {pat(1), 2'h0}, dac_code[1]);
    chk("digital red", 8'h92, digital_offset[0]);
    chk("digital green", 8'h80, digital_offset[1]);
    chk("digital blue", 8'h00, digital_offset[2]);
    auto_black_level_comp <= 0;
    ext_clamp_sel <= 1;
    clamp_pulse <= 1;
    wr(8'h2C, 8'h40);
    chk("ext held", 10'h200, dac_code[2]);
    clamp_pulse <= 0;
    clamp();
    chk("ext edge", 10'h100, dac_code[2]);
    wrap_up();
  end
endmodule : video_afe_offset_pll_config_regs_bench
